/* File: design/scrd_regs.sv */
// Purpose: Reset release delay and step-down converter configuration registers
// Assumes: Events and setting select are synchronous one-clock signals
// Notes: Read data appears one cycle after the read strobe
//
// The strobed register port was left to the implementer.
module scrd_regs
   import scrd_pkg::*;
#(
   parameter longint TICK_CYC = SCRD_TICK_CYC
) (
   input wire logic clock,
   input wire logic srst,
   input wire scrd_bus_req_s bus_req,
   output logic [7:0] rdata,
   input wire scrd_events_s events,
   input wire logic setting_b_active,
   input wire logic conv1_half_current,
   output logic system_reset_out_n,
   output scrd_conv_ctl_s conv1_ctl,
   output scrd_conv_ctl_s conv2_ctl,
   output scrd_conv_ctl_s conv3_ctl
);

   localparam int TW = $clog2(TICK_CYC + 1);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0] rst_delay;
      logic [7:0] c1_lim;
      logic [7:0] c2_lim;
      logic [7:0] c3_lim;
      logic [7:0] c1_cfg;
      logic [7:0] c2_cfg;
      logic [7:0] c3_cfg;
      logic [5:0] sleep_sel;
      logic [7:0] rdata;
      scrd_state_e st;
      logic [TW-1:0] tick_cnt;
      logic [10:0] ticks_left;
      logic rst_n;
      scrd_conv_ctl_s ctl1;
      scrd_conv_ctl_s ctl2;
      scrd_conv_ctl_s ctl3;
   } scrd_regs_s;

   scrd_regs_s s_q;
   scrd_regs_s s_d;

   // Mode decode shared by the three converters
   function automatic scrd_conv_ctl_s conv_mode(input logic [7:0] cfg, input logic sleep_a,
                                                input logic sleep_b, input logic use_b,
                                                input logic [12:0] lim);
      scrd_conv_ctl_s c;
      logic sl;
      c = '0;
      sl = use_b ? sleep_b : sleep_a;
      c.limit_ma = lim;
      c.pulldown_on = ~cfg[SCRD_PD_BIT];
      unique case (scrd_op_e'(cfg[SCRD_TRIG_HI:SCRD_TRIG_LO]))
         SCRD_OP_SLEEPBITS: begin
            c.pfm = sl;
            c.pwm = ~sl;
         end
         SCRD_OP_PFM: c.pfm = 1'b1;
         SCRD_OP_PWM: c.pwm = 1'b1;
         SCRD_OP_AUTO: c.auto_mode = 1'b1;
      endcase
      return c;
   endfunction

   // Trigger selected by software
   logic trig_hit;
   logic [5:0] dly_code;
   logic [10:0] dly_ticks;
   logic [12:0] lim1;
   always_comb begin
      unique case (scrd_trig_e'(s_q.rst_delay[SCRD_TRIG_HI:SCRD_TRIG_LO]))
         SCRD_TRIG_WAKE: trig_hit = events.external_wake_event;
         SCRD_TRIG_SYSUP: trig_hit = events.system_up_event;
         SCRD_TRIG_PWRUP: trig_hit = events.power_up_event;
         SCRD_TRIG_RSTEXIT: trig_hit = events.reset_mode_exit_event;
      endcase
      dly_code = s_q.rst_delay[SCRD_DLY_HI:SCRD_DLY_LO];
      if (dly_code[SCRD_DLY_LONG_BIT]) begin
         dly_ticks = 11'((dly_code - SCRD_DLY_LONG_BASE)) << SCRD_DLY_LONG_SHIFT;
      end else begin
         dly_ticks = 11'(dly_code);
      end
      lim1 = SCRD_C1_LIM_BASE + 13'(s_q.c1_lim[SCRD_LIM_HI:SCRD_LIM_LO] * SCRD_C1_LIM_STEP);
      if (conv1_half_current) begin
         lim1 = lim1 >> 1;
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      // Register writes
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            SCRD_OFS_RST_DELAY: s_d.rst_delay = bus_req.wdata;
            SCRD_OFS_C2_LIMIT: s_d.c2_lim = bus_req.wdata;
            SCRD_OFS_C3_LIMIT: s_d.c3_lim = bus_req.wdata;
            SCRD_OFS_C1_LIMIT: s_d.c1_lim = bus_req.wdata;
            SCRD_OFS_C1_CFG: s_d.c1_cfg = bus_req.wdata;
            SCRD_OFS_C3_CFG: s_d.c3_cfg = bus_req.wdata;
            SCRD_OFS_C2_CFG: s_d.c2_cfg = bus_req.wdata;
            SCRD_OFS_SLEEP_SEL: s_d.sleep_sel = bus_req.wdata[5:0];
            default: ;
         endcase
      end
      // Register reads, unmapped reads as zero
      s_d.rdata = SCRD_REG_RESET;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            SCRD_OFS_RST_DELAY: s_d.rdata = s_q.rst_delay;
            SCRD_OFS_C2_LIMIT: s_d.rdata = s_q.c2_lim & SCRD_RSVD_MASK_LIMIT;
            SCRD_OFS_C3_LIMIT: s_d.rdata = s_q.c3_lim;
            SCRD_OFS_C1_LIMIT: s_d.rdata = s_q.c1_lim;
            SCRD_OFS_C1_CFG: s_d.rdata = s_q.c1_cfg;
            SCRD_OFS_C3_CFG: s_d.rdata = s_q.c3_cfg;
            SCRD_OFS_C2_CFG: s_d.rdata = s_q.c2_cfg;
            SCRD_OFS_SLEEP_SEL: s_d.rdata = {2'h0, s_q.sleep_sel};
            SCRD_OFS_STATUS: s_d.rdata = {4'h0, s_q.st == SCRD_ST_COUNT, s_q.rst_n,
                                          s_q.st == SCRD_ST_DONE, setting_b_active};
            default: s_d.rdata = SCRD_REG_RESET;
         endcase
      end
      // Reset release sequencer; tick prescaler runs only while counting
      unique case (s_q.st)
         SCRD_ST_IDLE: begin
            if (trig_hit) begin
               s_d.tick_cnt = '0;
               s_d.ticks_left = dly_ticks;
               if (dly_ticks == SCRD_DLY_ZERO) begin
                  s_d.rst_n = 1'b1;
                  s_d.st = SCRD_ST_DONE;
               end else begin
                  s_d.st = SCRD_ST_COUNT;
               end
            end
         end
         SCRD_ST_COUNT: begin
            if (s_q.tick_cnt == TW'(TICK_CYC - 1)) begin
               s_d.tick_cnt = '0;
               s_d.ticks_left = s_q.ticks_left - 11'h001;
               if (s_q.ticks_left == 11'h001) begin
                  s_d.rst_n = 1'b1;
                  s_d.st = SCRD_ST_DONE;
               end
            end else begin
               s_d.tick_cnt = s_q.tick_cnt + TW'(1);
            end
         end
         SCRD_ST_DONE: ;
      endcase
      // Converter controls
      s_d.ctl1 = conv_mode(s_q.c1_cfg, s_q.sleep_sel[0], s_q.sleep_sel[1], setting_b_active, lim1);
      s_d.ctl2 = conv_mode(s_q.c2_cfg, s_q.sleep_sel[2], s_q.sleep_sel[3], setting_b_active,
                           SCRD_C2_LIM_BASE + 13'(s_q.c2_lim[SCRD_LIM_HI:SCRD_LIM_LO] * SCRD_LIM_STEP));
      s_d.ctl3 = conv_mode(s_q.c3_cfg, s_q.sleep_sel[4], s_q.sleep_sel[5], setting_b_active,
                           SCRD_C3_LIM_BASE + 13'(s_q.c3_lim[SCRD_LIM_HI:SCRD_LIM_LO] * SCRD_LIM_STEP));
   end

   // State register
   always_ff @(posedge clock) begin
      if (srst) begin
         s_q <= '0;
         s_q.st <= SCRD_ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign rdata = s_q.rdata;
   assign system_reset_out_n = s_q.rst_n;
   assign conv1_ctl = s_q.ctl1;
   assign conv2_ctl = s_q.ctl2;
   assign conv3_ctl = s_q.ctl3;

endmodule

/* File: design/scrd_pkg.sv */
// Purpose: Constants and carriers for the supply configuration and reset delay registers
// Assumes: 50 MHz clock, 8-bit register port
// Notes: Offsets are byte addresses on the plain register port
package scrd_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] SCRD_OFS_RST_DELAY = 8'h99;
   localparam logic [7:0] SCRD_OFS_C2_LIMIT = 8'h9A;
   localparam logic [7:0] SCRD_OFS_C3_LIMIT = 8'h9B;
   localparam logic [7:0] SCRD_OFS_C1_LIMIT = 8'h9C;
   localparam logic [7:0] SCRD_OFS_C1_CFG = 8'h9E;
   localparam logic [7:0] SCRD_OFS_C3_CFG = 8'h9F;
   localparam logic [7:0] SCRD_OFS_C2_CFG = 8'hA0;
   localparam logic [7:0] SCRD_OFS_SLEEP_SEL = 8'hA1;
   localparam logic [7:0] SCRD_OFS_STATUS = 8'hA2;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int SCRD_TRIG_HI = 7;
   localparam int SCRD_TRIG_LO = 6;
   localparam int SCRD_DLY_HI = 5;
   localparam int SCRD_DLY_LO = 0;
   localparam int SCRD_PD_BIT = 5;
   localparam int SCRD_LIM_HI = 3;
   localparam int SCRD_LIM_LO = 0;
   localparam int SCRD_DLY_LONG_BIT = 5;
   localparam logic [7:0] SCRD_REG_RESET = 8'h00;
   localparam logic [7:0] SCRD_RSVD_MASK_LIMIT = 8'h0F;
   localparam logic [5:0] SCRD_DLY_LONG_BASE = 6'h1F;
   localparam logic [10:0] SCRD_DLY_ZERO = 11'h000;
   localparam int SCRD_DLY_LONG_SHIFT = 5;

   // ****************************************
   // Current limits in mA
   // ****************************************
   // Thirteen bits: converter 1 reaches 4400 mA at code 15
   localparam logic [12:0] SCRD_C1_LIM_BASE = 13'h0578; // 1400 mA
   localparam logic [12:0] SCRD_C1_LIM_STEP = 13'h00C8; // 200 mA
   localparam logic [12:0] SCRD_C2_LIM_BASE = 13'h06A4; // 1700 mA
   localparam logic [12:0] SCRD_C3_LIM_BASE = 13'h02BC; // 700 mA
   localparam logic [12:0] SCRD_LIM_STEP = 13'h0064;    // 100 mA

   // ****************************************
   // Timing
   // ****************************************
   localparam longint SCRD_CLK_HZ = 50000000;
   localparam longint SCRD_TICK_NS = 1024000;           // 1.024 ms
   localparam longint SCRD_TICK_CYC = (SCRD_TICK_NS * SCRD_CLK_HZ) / 1000000000;

   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [1:0] {
      SCRD_TRIG_WAKE = 2'h0,
      SCRD_TRIG_SYSUP = 2'h1,
      SCRD_TRIG_PWRUP = 2'h2,
      SCRD_TRIG_RSTEXIT = 2'h3
   } scrd_trig_e;

   typedef enum logic [1:0] {
      SCRD_OP_SLEEPBITS = 2'h0,
      SCRD_OP_PFM = 2'h1,
      SCRD_OP_PWM = 2'h2,
      SCRD_OP_AUTO = 2'h3
   } scrd_op_e;

   typedef enum logic [2:0] {
      SCRD_ST_IDLE = 3'h1,
      SCRD_ST_COUNT = 3'h2,
      SCRD_ST_DONE = 3'h4
   } scrd_state_e;

   // Register bus carriers
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } scrd_bus_req_s;

   // Trigger events from the power sequencer
   typedef struct packed {
      logic external_wake_event;
      logic system_up_event;
      logic power_up_event;
      logic reset_mode_exit_event;
   } scrd_events_s;

   // Per-converter control to the analog side
   typedef struct packed {
      logic [12:0] limit_ma;
      logic pfm;
      logic pwm;
      logic auto_mode;
      logic pulldown_on;
   } scrd_conv_ctl_s;

endpackage

/* File: bench/scrd_regs_props.sv */
// Purpose: Port assertions for scrd_regs
// Assumes: One clock, synchronous active-high reset
// Notes: Shadows the delay register to time the release
module scrd_regs_props
   import scrd_pkg::*;
#(
   parameter longint TICK_CYC = SCRD_TICK_CYC
) (
   input wire logic clock,
   input wire logic srst,
   input wire scrd_bus_req_s bus_req,
   input wire logic [7:0] rdata,
   input wire scrd_events_s events,
   input wire logic setting_b_active,
   input wire logic conv1_half_current,
   input wire logic system_reset_out_n,
   input wire scrd_conv_ctl_s conv1_ctl,
   input wire scrd_conv_ctl_s conv2_ctl,
   input wire scrd_conv_ctl_s conv3_ctl
);
   logic [7:0] shd_q;
   logic go_q;
   longint cnt_q;
   longint exp_q;
   wire logic [3:0] ev = events;
   wire logic [5:0] d = shd_q[5:0];
   // Latch the hold time at the trigger edge, then count cycles
   always_ff @(posedge clock) begin
      if (srst) begin
         shd_q <= 8'h00;
         go_q <= 1'h0;
         cnt_q <= 0;
         exp_q <= 0;
      end else begin
         if (bus_req.wr && bus_req.addr == 8'h99) shd_q <= bus_req.wdata;
         if (!go_q && ev[2'h3 - shd_q[7:6]]) begin
            go_q <= 1'h1;
            cnt_q <= 1;
            exp_q <= (d == 6'h00) ? 1 : (d < 6'h20) ? d * TICK_CYC + 1 : (d - 31) * 32 * TICK_CYC + 1;
         end else if (go_q) cnt_q <= cnt_q + 1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_trig;
      !go_q ##1 go_q;
   endsequence
   a_read_quiet: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
      else $error("read data outside answer cycle");
   a_held_idle: assert property (!go_q |-> !system_reset_out_n)
      else $error("release without selected trigger");
   a_held_count: assert property (go_q && cnt_q < exp_q |-> !system_reset_out_n)
      else $error("release too early");
   a_release_time: assert property (go_q && cnt_q >= exp_q |-> system_reset_out_n)
      else $error("release too late");
   a_zero_release: assert property (s_trig ##0 exp_q == 1 |-> system_reset_out_n)
      else $error("zero delay not immediate");
   a_stays_high: assert property (system_reset_out_n |=> system_reset_out_n)
      else $error("reset output fell again");
   a_mode_onehot: assert property (!$past(srst) |-> $onehot({conv1_ctl.pfm, conv1_ctl.pwm, conv1_ctl.auto_mode}))
      else $error("mode not one-hot");
   a_lim2_range: assert property (!$past(srst) |-> conv2_ctl.limit_ma inside {[13'h06A4:13'h0C80]})
      else $error("limit 2 out of range");
   a_lim3_range: assert property (!$past(srst) |-> conv3_ctl.limit_ma inside {[13'h02BC:13'h0898]})
      else $error("limit 3 out of range");
endmodule
bind scrd_regs scrd_regs_props #(.TICK_CYC(TICK_CYC)) i_props (.clock, .srst, .bus_req, .rdata, .events,
   .setting_b_active, .conv1_half_current, .system_reset_out_n, .conv1_ctl, .conv2_ctl, .conv3_ctl);

/* File: bench/scrd_regs_test.sv */
// Purpose: Self-checking bench for scrd_regs
// Assumes: Tick shortened to 4 cycles
// Notes: Integer register model drives the read and control expectations
module scrd_regs_test
   import scrd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam longint TK = 4;
   logic clock = 1'h0;
   logic srst = 1'h1;
   scrd_bus_req_s bus_req = '0;
   scrd_events_s events = '0;
   logic setting_b_active = 1'h0;
   logic conv1_half_current = 1'h0;
   logic [7:0] rdata;
   logic system_reset_out_n;
   scrd_conv_ctl_s c1, c2, c3;
   int err_count = 0;
   int n_tests = 0;
   int seed = 32'hA923;
   int m [256];
   scrd_regs #(.TICK_CYC(TK)) i_dut (.clock, .srst, .bus_req, .rdata, .events, .setting_b_active,
      .conv1_half_current, .system_reset_out_n, .conv1_ctl(c1), .conv2_ctl(c2), .conv3_ctl(c3));
   initial forever #10 clock = ~clock;
   // Report and verdict
   task automatic fail(string s);
      err_count++;
      $display("unexpected at %0t: %s", $time, s);
   endtask
   task automatic summarize;
      $display("mismatches %0d, comparisons %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk8(logic [7:0] got, logic [7:0] exp);
      n_tests++;
      if (got !== exp) fail($sformatf("byte %h, want %h", got, exp));
   endtask
   task automatic chk_ctl(scrd_conv_ctl_s got, scrd_conv_ctl_s exp);
      n_tests++;
      if (got !== exp) fail($sformatf("control %h, want %h", got, exp));
   endtask
   task automatic chk_n(int got, int exp);
      n_tests++;
      if (got != exp) fail($sformatf("hold %0d cycles, want %0d", got, exp));
   endtask
   // Register port cycles
   task automatic wr(logic [7:0] a, logic [7:0] v);
      @(posedge clock);
      bus_req <= '{a, v, 1'h1, 1'h0};
      @(posedge clock);
      bus_req.wr <= 1'h0;
      if (a inside {[8'h99:8'hA1]} && a != 8'h9D) m[a] = v;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clock);
      bus_req <= '{a, 8'h00, 1'h0, 1'h1};
      @(posedge clock);
      bus_req.rd <= 1'h0;
      @(negedge clock);
      chk8(rdata, a == 8'h9A ? m[a][7:0] & 8'h0F : m[a][7:0]);
   endtask
   task automatic pulse(logic [3:0] e);
      @(posedge clock);
      events <= e;
      @(posedge clock);
      events <= '0;
   endtask
   task automatic do_reset(int n);
      srst <= 1'h1;
      repeat (n) @(posedge clock);
      srst <= 1'h0;
      foreach (m[i]) m[i] = 0;
   endtask
   // Expected converter control from the model
   function automatic scrd_conv_ctl_s mctl(int n);
      int cfg, sl, lim;
      scrd_conv_ctl_s c;
      cfg = m[n == 1 ? 8'h9E : n == 2 ? 8'hA0 : 8'h9F];
      sl = m[8'hA1] >> (2 * n - 2 + setting_b_active);
      lim = n == 1 ? 1400 + (m[8'h9C] & 15) * 200 : n == 2 ? 1700 + (m[8'h9A] & 15) * 100 : 700 + (m[8'h9B] & 15) * 100;
      if (n == 1 && conv1_half_current) lim = lim / 2;
      c.limit_ma = lim[12:0];
      c.pfm = cfg[7:6] == 1 || (cfg[7:6] == 0 && sl[0]);
      c.pwm = cfg[7:6] == 2 || (cfg[7:6] == 0 && !sl[0]);
      c.auto_mode = cfg[7:6] == 3;
      c.pulldown_on = !cfg[5];
      return c;
   endfunction
   // Main sequence
   initial begin
      int d, t, n, a;
      logic [7:0] v;
      int dl[5] = '{0, 1, 31, 32, 63};
      do_reset(20);
      for (a = 8'h98; a <= 8'hA0; a++) rd(a[7:0]);
      for (int i = 0; i < 40; i++) begin
         a = 8'h98 + i % 10;
         v = $random(seed);
         v[7:6] = 2'(i / 10);
         @(posedge clock);
         setting_b_active <= v[0];
         conv1_half_current <= v[1];
         wr(a[7:0], v);
         if (a != 8'hA1) rd(a[7:0]);
         // Controls follow the register one clock later
         repeat (2) @(negedge clock);
         chk_ctl(c1, mctl(1));
         chk_ctl(c2, mctl(2));
         chk_ctl(c3, mctl(3));
      end
      for (int i = 0; i < 5; i++) begin
         do_reset(2);
         d = dl[i];
         t = i % 4;
         wr(8'h99, {t[1:0], d[5:0]});
         pulse(~(4'h8 >> t));
         repeat (3) @(posedge clock);
         chk8({7'h00, system_reset_out_n}, 8'h00);
         pulse(4'h8 >> t);
         n = 0;
         while (system_reset_out_n !== 1'h1 && n < 5000) begin
            @(posedge clock);
            n++;
            #1;
         end
         chk_n(n, d == 0 ? 1 : d < 32 ? d * TK : (d - 31) * 32 * TK);
      end
      summarize();
   end
   // Watchdog against a hang
   initial begin
      #1000000;
      fail("watchdog expired");
      summarize();
   end
endmodule
